// >>> lgfb_top.sv
// logic gate function blocks plus special-block common input handling
`timescale 1ns/1ps
module lgfb_top #(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic [3:0]        and_in,
    input  wire logic [3:0]        and_conn,
    input  wire logic [3:0]        or_in,
    input  wire logic [3:0]        or_conn,
    input  wire logic [1:0]        xor_in,
    input  wire logic [1:0]        xor_conn,
    input  wire logic              not_in,
    input  wire logic              sb_set,
    input  wire logic              sb_reset,
    input  wire logic              sb_trigger,
    input  wire logic              sb_count,
    input  wire logic              sb_dir,
    input  wire logic              sb_enable,
    input  wire logic              sb_invert,
    input  wire logic              sb_reset_all,
    input  wire logic [7:0]        sb_conn,
    input  wire logic [CNT_W-1:0]  sb_param_limit,
    output logic                   and_out,
    output logic                   and_edge_out,
    output logic                   nand_out,
    output logic                   nand_edge_out,
    output logic                   or_out,
    output logic                   nor_out,
    output logic                   xor_out,
    output logic                   not_out,
    output logic                   sb_out,
    output logic                   sb_running,
    output logic [CNT_W-1:0]       sb_count_value,
    output logic                   sb_limit_hit
);

    if (CNT_W < 2 || CNT_W > 32) begin : g_chk
        $error("lgfb_top: CNT_W must be 2..32");
    end

    ////////////////////////////////////////////////////////////////////////
    // input tying per gate family

    logic [3:0] and_eff;
    logic [3:0] or_eff;
    logic [1:0] xor_eff;
    logic [7:0] sb_eff;

    // one generate loop ties each unconnected and/or lane to its family level; xor lanes are tied low below it
    for (genvar i = 0; i < lgfb_pkg::GATE_INPUTS; i++) begin : g_tie
        assign and_eff[i] = and_conn[i] ? and_in[i]
                                        : lgfb_pkg::AND_TIE[i];
        assign or_eff[i]  = or_conn[i] ? or_in[i]
                                       : lgfb_pkg::OR_TIE[i];
    end
    assign xor_eff[0] = xor_conn[0] & xor_in[0];
    assign xor_eff[1] = xor_conn[1] & xor_in[1];

    // special inputs: set, reset, trigger, count, dir, enable, invert, ral
    assign sb_eff = sb_conn & {sb_reset_all, sb_invert, sb_enable, sb_dir,
                               sb_count, sb_trigger, sb_reset,
                               sb_set};

    ////////////////////////////////////////////////////////////////////////
    // basic gates, registered once per program cycle

    logic [3:0] prev_reg;
    logic [3:0] prev_next;
    logic [7:0] gate_reg;
    logic [7:0] gate_next;
    logic       and_all;
    logic       prev_all;

    always_comb begin
        and_all   = &and_eff;
        prev_all  = &prev_reg;
        prev_next = and_eff;
        gate_next[0] = and_all;
        gate_next[1] = and_all & ~prev_all;
        gate_next[2] = ~and_all;
        gate_next[3] = ~and_all & prev_all;
        gate_next[4] = |or_eff;
        gate_next[5] = ~(|or_eff);
        gate_next[6] = xor_eff[0] ^ xor_eff[1];
        gate_next[7] = ~not_in;
    end

    // history starts at zero, so an all-ones first cycle counts as an edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prev_reg <= lgfb_pkg::PREV_RST;
            gate_reg <= 8'h00;
        end else if (clk_en) begin
            prev_reg <= prev_next;
            gate_reg <= gate_next;
        end
    end

    assign and_out       = gate_reg[0];
    assign and_edge_out  = gate_reg[1];
    assign nand_out      = gate_reg[2];
    assign nand_edge_out = gate_reg[3];
    assign or_out        = gate_reg[4];
    assign nor_out       = gate_reg[5];
    assign xor_out       = gate_reg[6];
    assign not_out       = gate_reg[7];

    ////////////////////////////////////////////////////////////////////////
    // special block: set/reset latch, triggered up/down pulse tally

    logic             s_set, s_rst, s_trg, s_cnt, s_dir, s_en, s_inv, s_ral;
    logic             latch_reg;
    logic             latch_next;
    logic             run_reg;
    logic             run_next;
    logic             cnt_prev_reg;
    logic             cnt_prev_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             out_reg;
    logic             out_next;
    logic             hit_reg;
    logic             hit_next;

    assign {s_ral, s_inv, s_en, s_dir, s_cnt, s_trg, s_rst, s_set} = sb_eff;

    always_comb begin
        latch_next    = latch_reg;
        run_next      = run_reg;
        cnt_prev_next = s_cnt;
        cnt_next      = cnt_reg;
        if (s_ral) begin
            latch_next    = lgfb_pkg::OUT_RST;
            run_next      = 1'b0;
            cnt_prev_next = 1'b0;
            cnt_next      = lgfb_pkg::CNT_RST[CNT_W-1:0];
        end else if (s_rst) begin
            latch_next = lgfb_pkg::OUT_RST;
            run_next   = 1'b0;
        end else if (s_en) begin
            if (s_set) begin
                latch_next = 1'b1;
            end
            if (s_trg) begin
                run_next = 1'b1;
            end
            if (run_reg && s_cnt && !cnt_prev_reg) begin
                cnt_next = s_dir ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
            end
        end
        // limit is a configured value, only compared, never a live signal
        hit_next = (cnt_next == sb_param_limit);
        // a disabled block ignores invert as well, so the output holds unless reset or reset all clears it
        out_next = s_en ? (latch_next ^ s_inv) : out_reg;
        if (s_rst || s_ral) begin
            out_next = lgfb_pkg::OUT_RST;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            latch_reg    <= lgfb_pkg::OUT_RST;
            run_reg      <= 1'b0;
            cnt_prev_reg <= 1'b0;
            cnt_reg      <= lgfb_pkg::CNT_RST[CNT_W-1:0];
            out_reg      <= lgfb_pkg::OUT_RST;
            hit_reg      <= 1'b0;
        end else if (clk_en) begin
            latch_reg    <= latch_next;
            run_reg      <= run_next;
            cnt_prev_reg <= cnt_prev_next;
            cnt_reg      <= cnt_next;
            out_reg      <= out_next;
            hit_reg      <= hit_next;
        end
    end

    assign sb_out         = out_reg;
    assign sb_running     = run_reg;
    assign sb_count_value = cnt_reg;
    assign sb_limit_hit   = hit_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_and_output: assert property (clk_en |=> and_out == $past(&and_eff))
        else $error("and output wrong");
    a_and_edge: assert property (clk_en ##1 clk_en |=> and_edge_out ==
        ((&$past(and_eff)) && !(&$past(and_eff, 2))))
        else $error("edge and output wrong");
    a_and_tie: assert property (clk_en && and_conn == 4'h0 |=> and_out)
        else $error("unconnected and input not high");
    a_nand_pair: assert property (clk_en |=> nand_out == !$past(&and_eff))
        else $error("nand not complement of and");
    a_nand_edge: assert property (clk_en ##1 clk_en |=> nand_edge_out ==
        (!(&$past(and_eff)) && (&$past(and_eff, 2))))
        else $error("edge nand output wrong");
    a_or_output: assert property (clk_en |=> or_out == $past(|or_eff))
        else $error("or output wrong");
    a_or_tie: assert property (clk_en && or_conn == 4'h0 |=> !or_out)
        else $error("unconnected or input not low");
    a_nor_pair: assert property (clk_en |=> nor_out == !$past(|or_eff))
        else $error("nor not complement of or");
    a_xor_output: assert property (clk_en |=>
        xor_out == $past(xor_eff[0] ^ xor_eff[1]))
        else $error("xor output wrong");
    a_not_output: assert property (clk_en |=> not_out == !$past(not_in))
        else $error("not output wrong");
    a_sb_set: assert property (clk_en && s_en && s_set && !s_rst && !s_ral
        && !s_inv |=> sb_out)
        else $error("set did not raise output");
    a_sb_reset: assert property (clk_en && (s_rst || s_ral) |=> !sb_out
        && !sb_running)
        else $error("reset did not clear block");
    a_sb_enable: assert property (clk_en && !s_en && !s_rst && !s_ral |=>
        $stable(sb_count_value) && $stable(sb_running)
        && $stable(sb_out))
        else $error("disabled block changed");
    a_sb_ral: assert property (clk_en && s_ral |=> sb_count_value == '0)
        else $error("reset all left count");

    // a paused program cycle freezes every gate output and the history
    a_gate_freeze: assert property (!clk_en |=> $stable(gate_reg)
        && $stable(prev_reg))
        else $error("gate state moved while paused");

    // tie levels seen through the negated and two-input gates
    a_nand_tie: assert property (clk_en && and_conn == 4'h0 |=>
        !nand_out)
        else $error("unconnected nand input not high");
    a_nor_tie: assert property (clk_en && or_conn == 4'h0 |=>
        nor_out)
        else $error("unconnected nor input not low");
    a_xor_tie: assert property (clk_en && xor_conn == 2'h0 |=>
        !xor_out)
        else $error("unconnected xor input not low");

    // latch, start and tally behaviour of the special block
    a_sb_invert: assert property (clk_en && s_en && s_set && s_inv
        && !s_rst && !s_ral |=> !sb_out)
        else $error("invert did not flip output");
    a_sb_trigger: assert property (clk_en && s_en && s_trg
        && !s_rst && !s_ral |=> sb_running)
        else $error("trigger did not start block");
    a_sb_idle_cnt: assert property (clk_en && !sb_running
        && !s_ral |=> $stable(sb_count_value))
        else $error("count moved before start");
    a_sb_count_up: assert property (clk_en && s_en && !s_rst && !s_ral
        && sb_running && s_cnt && !cnt_prev_reg && !s_dir |=>
        sb_count_value == $past(sb_count_value) + 1'b1)
        else $error("count did not step up");
    a_sb_count_dn: assert property (clk_en && s_en && !s_rst && !s_ral
        && sb_running && s_cnt && !cnt_prev_reg && s_dir |=>
        sb_count_value == $past(sb_count_value) - 1'b1)
        else $error("count did not step down");

    // the limit flag follows the count it is shown with
    a_sb_limit: assert property (clk_en |=> sb_limit_hit ==
        (sb_count_value == $past(sb_param_limit)))
        else $error("limit flag wrong");
    a_sb_hit_clear: assert property (clk_en && s_ral
        && sb_param_limit != '0 |=> !sb_limit_hit)
        else $error("reset all left limit flag");

    // an open set input never raises a cleared latch
    a_sb_unused: assert property (clk_en && s_en && !sb_conn[0]
        && !latch_reg && !s_inv |=> !sb_out)
        else $error("unconnected set input acted");

    // main scenarios the bench has to reach
    c_and_edge: cover property (and_edge_out);
    c_nand_edge: cover property (nand_edge_out);
    c_sb_count: cover property (sb_count_value == 16'h0003);
    c_sb_hit: cover property (sb_limit_hit && sb_running);
    c_sb_down: cover property (clk_en && s_en && s_dir && s_cnt && sb_running);

endmodule : lgfb_top

// >>> lgfb_pkg.sv
// package of constants for the logic gate function blocks
package lgfb_pkg;
    localparam int unsigned GATE_INPUTS  = 4;
    localparam logic [3:0]  AND_TIE      = 4'hf;
    localparam logic [3:0]  OR_TIE       = 4'h0;
    localparam logic [3:0]  PREV_RST     = 4'h0;
    localparam logic        OUT_RST      = 1'h0;
    localparam logic [1:0]  SB_TIE       = 2'h0;
    localparam logic [15:0] CNT_RST      = 16'h0000;
endpackage : lgfb_pkg

// >>> lgfb_lane_src.sv
// far-side model: upstream blocks that drive the and and or gate input lanes
`timescale 1ns/1ps
module lgfb_lane_src (
    input  wire logic       ref_clk,
    input  wire logic [3:0] and_pat,
    input  wire logic [3:0] and_conn,
    input  wire logic [3:0] or_pat,
    input  wire logic [3:0] or_conn,
    output logic      [3:0] and_in,
    output logic      [3:0] or_in
);
    logic [3:0] and_last = 4'h0;
    logic [3:0] or_last  = 4'h0;
    // an undriven lane toggles every cycle, so no lucky settled value
    // can stand in for the tie level the gate must supply
    always_comb begin
        and_in = (and_pat & and_conn) | (~and_last & ~and_conn);
        or_in  = (or_pat & or_conn) | (~or_last & ~or_conn);
    end
    always_ff @(posedge ref_clk) begin
        and_last <= and_in;
        or_last  <= or_in;
    end
endmodule : lgfb_lane_src

// >>> lgfb_top_tb.sv
// self-checking bench for the logic gate function blocks
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module lgfb_top_tb;
    localparam int unsigned CNT_W = 8;
    logic             ref_clk = 1'b0;
    logic             rst_n   = 1'b0;
    logic             clk_en  = 1'b1;
    logic             not_in  = 1'b0;
    logic [3:0]       and_pat = 4'h0, and_conn = 4'h0, and_in, a;
    logic [3:0]       or_pat  = 4'h0, or_conn  = 4'h0, or_in, o;
    logic [3:0]       prev    = 4'h0;
    logic [1:0]       xor_in  = 2'h0, xor_conn = 2'h0;
    logic [7:0]       sbv     = 8'h00, sb_conn = 8'hff;
    logic             and_out, and_edge_out, nand_out, nand_edge_out;
    logic             or_out, nor_out, xor_out, not_out;
    logic             sb_out, sb_running, sb_limit_hit;
    logic [CNT_W-1:0] sb_count_value;
    int               fails = 0, n_checks = 0;
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    lgfb_lane_src u_lgfb_lane_src (.ref_clk(ref_clk), .and_pat(and_pat),
        .and_conn(and_conn), .or_pat(or_pat), .or_conn(or_conn),
        .and_in(and_in), .or_in(or_in));
    lgfb_top #(.CNT_W(CNT_W)) u_lgfb_top (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .and_in(and_in), .and_conn(and_conn),
        .or_in(or_in), .or_conn(or_conn), .xor_in(xor_in),
        .xor_conn(xor_conn), .not_in(not_in), .sb_set(sbv[0]),
        .sb_reset(sbv[1]), .sb_trigger(sbv[2]), .sb_count(sbv[3]),
        .sb_dir(sbv[4]), .sb_enable(sbv[5]), .sb_invert(sbv[6]),
        .sb_reset_all(sbv[7]), .sb_conn(sb_conn), .sb_param_limit(8'h03),
        .and_out(and_out), .and_edge_out(and_edge_out),
        .nand_out(nand_out), .nand_edge_out(nand_edge_out),
        .or_out(or_out), .nor_out(nor_out), .xor_out(xor_out),
        .not_out(not_out), .sb_out(sb_out), .sb_running(sb_running),
        .sb_count_value(sb_count_value), .sb_limit_hit(sb_limit_hit));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // count is looked at only on low count steps, where it has settled
    task automatic sb_step(input logic [7:0] v, input logic e, input int c);
        sbv = v;
        @(posedge ref_clk);
        #1;
        `CHK(sb_out, e)
        if (!v[3]) begin
            `CHK(sb_count_value, CNT_W'(c))
            `CHK(sb_limit_hit, c == 3)
        end
    endtask : sb_step
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'he723));
        repeat (5) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge ref_clk);
            #1;
            if (!rst_n) begin
                prev = 4'h0;
            end else if (clk_en) begin
                a = and_in | ~and_conn;
                o = or_in & or_conn;
                `CHK(and_out, &a)
                `CHK(and_edge_out, &a & ~&prev)
                `CHK(nand_out, ~&a)
                `CHK(nand_edge_out, ~&a & &prev)
                `CHK(or_out, |o)
                `CHK(nor_out, ~|o)
                `CHK(xor_out, ^(xor_in & xor_conn))
                `CHK(not_out, ~not_in)
                prev = a;
            end
            rst_n    = (i != 200);
            clk_en   = (i == 399) || (($urandom % 4) != 0);
            // mostly all-high vectors so the edge gates really fire
            and_pat  = ($urandom % 2) ? 4'hf : 4'($urandom);
            and_conn = 4'($urandom);
            or_pat   = 4'($urandom);
            or_conn  = 4'($urandom);
            xor_in   = 2'($urandom);
            xor_conn = 2'($urandom);
            not_in   = 1'($urandom);
        end
        sb_step(8'h01, 1'b0, 0);
        sb_step(8'h21, 1'b1, 0);
        sb_step(8'h20, 1'b1, 0);
        sb_step(8'h60, 1'b0, 0);
        sb_step(8'h23, 1'b0, 0);
        sb_conn = 8'hfe;
        sb_step(8'h21, 1'b0, 0);
        sb_conn = 8'hff;
        sb_step(8'h24, 1'b0, 0);
        `CHK(sb_running, 1'b1)
        for (int k = 1; k <= 3; k++) begin
            sb_step(8'h28, 1'b0, 0);
            sb_step(8'h20, 1'b0, k);
        end
        sb_step(8'h38, 1'b0, 0);
        sb_step(8'h30, 1'b0, 2);
        sb_step(8'h08, 1'b0, 0);
        sb_step(8'h00, 1'b0, 2);
        sb_step(8'h80, 1'b0, 0);
        `CHK(sb_running, 1'b0)
        report_and_stop();
    end
endmodule : lgfb_top_tb
